// *** rtl/ccfa_top.sv ***
// cycle counter with filter register and guarded coprocessor access
//
// Function
// - privileged bit 31 stops level 1 counting
// - user bit 30 stops level 0 counting
// - non-secure level 1 counts when bit 29 matches
// - non-secure level 0 counts when bit 28 matches
// - bit 27 enables level 2 counting
// - realm level 0 counts when bit 21 matches
// - warm reset clears bits 31 to 27 and bit 21
// - unused and absent bits read zero
// - one 32-bit storage shared by all views
// - absent register makes access undefined
// - indirect port reaches it at select 31
// - direct encoding cp15, opc1 0, c14 c15 7
// - user access disabled traps level 0 accesses
// - fine-grained read/write traps go to level 2
// - hypervisor monitor trap goes to level 2
// - level 3 monitor trap, or undefined when halted with secure debug disabled
`timescale 1ns/100ps
`include "ccfa_consts.svh"
module ccfa_top
  import ccfa_pkg::*;
#(
  parameter bit HAVE_AA32 = 1'b1,
  parameter bit HAVE_PMU = 1'b1,
  parameter bit HAVE_EL2 = 1'b1,
  parameter bit HAVE_EL3 = 1'b1,
  parameter bit HAVE_REALM = 1'b1,
  parameter bit EL3_TRAP_PRIO = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // coprocessor instruction port
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [3:0] cp_coproc,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic cp_indirect,
  input wire logic [4:0] counter_select_field,
  input wire logic [31:0] cp_wdata,
  // external view write port
  input wire logic ext_write,
  input wire logic [31:0] ext_wdata,
  // processor state
  input wire ccfa_el_e cur_el,
  input wire ccfa_ss_e cur_ss,
  input wire logic el2_enabled,
  input wire logic halted,
  // trap control bits
  input wire logic user_access_enable_bit,
  input wire logic trap_general_exceptions_bit,
  input wire logic host_mode_bit,
  input wire logic fine_trap_permit_bit,
  input wire logic fine_read_trap_bit,
  input wire logic fine_write_trap_bit,
  input wire logic hyp_monitor_trap_bit,
  input wire logic level3_monitor_trap_bit,
  input wire logic secure_debug_disabled_bit,
  // access answer
  output logic cp_done,
  output logic cp_undef,
  output logic cp_trap,
  output logic [1:0] cp_trap_el,
  output logic [5:0] cp_trap_ec,
  output logic [31:0] cp_rdata,
  // filter view and counter
  output logic [31:0] cycle_count_filter_view,
  output logic [63:0] cycle_counter,
  output logic count_active
);
  // ----------------------------------------
  // writable bit mask
  // ----------------------------------------
  localparam logic [31:0] WMASK =
      (32'h1 << `CCFA_P_BIT) | (32'h1 << `CCFA_U_BIT)
    | ((HAVE_EL3 ? 32'h1 : 32'h0) << `CCFA_NS_KERNEL_BIT)
    | ((HAVE_EL3 ? 32'h1 : 32'h0) << `CCFA_NS_USER_BIT)
    | ((HAVE_EL2 ? 32'h1 : 32'h0) << `CCFA_HYP_BIT)
    | ((HAVE_REALM ? 32'h1 : 32'h0) << `CCFA_REALM_USER_BIT);
  localparam bit PRESENT = HAVE_AA32 && HAVE_PMU;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic direct_hit;
  logic indirect_hit;
  logic hit;
  assign direct_hit = cp_coproc == `CCFA_COPROC && cp_opc1 == `CCFA_OPC1
    && cp_crn == `CCFA_CRN && cp_crm == `CCFA_CRM && cp_opc2 == `CCFA_OPC2;
  assign indirect_hit = cp_indirect && counter_select_field == `CCFA_SEL_CYCLE;
  assign hit = cp_valid && (direct_hit || indirect_hit);

  ccfa_res_e chk_result;
  ccfa_el_e chk_el;
  ccfa_access_check #(
    .HAVE_EL3(HAVE_EL3),
    .EL3_TRAP_PRIO(EL3_TRAP_PRIO)
  ) u_check (
    .is_write(cp_write),
    .cur_el(cur_el),
    .el2_enabled(el2_enabled && HAVE_EL2),
    .halted(halted),
    .user_access_enable_bit(user_access_enable_bit),
    .trap_general_exceptions_bit(trap_general_exceptions_bit),
    .host_mode_bit(host_mode_bit),
    .fine_trap_permit_bit(fine_trap_permit_bit),
    .fine_read_trap_bit(fine_read_trap_bit),
    .fine_write_trap_bit(fine_write_trap_bit),
    .hyp_monitor_trap_bit(hyp_monitor_trap_bit),
    .level3_monitor_trap_bit(level3_monitor_trap_bit),
    .secure_debug_disabled_bit(secure_debug_disabled_bit),
    .result(chk_result),
    .target_el(chk_el)
  );

  ccfa_res_e verdict;
  always_comb begin
    verdict = ccfa_none;
    if (hit) begin
      verdict = PRESENT ? chk_result : ccfa_undef;
    end
  end

  // ----------------------------------------
  // filter storage
  // ----------------------------------------
  logic [31:0] filter;
  logic [31:0] next_filter;
  always_comb begin
    next_filter = filter;
    // one storage for direct, indirect and external views
    if (verdict == ccfa_ok && cp_write) begin
      next_filter = cp_wdata & WMASK;
    end else if (ext_write && PRESENT) begin
      next_filter = ext_wdata & WMASK;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      filter <= `CCFA_FILTER_RESET;
    end else begin
      filter <= next_filter;
    end
  end
  assign cycle_count_filter_view = filter;

  // ----------------------------------------
  // answer registers
  // ----------------------------------------
  logic next_done;
  logic next_undef;
  logic next_trap;
  logic [1:0] next_trap_el;
  logic [5:0] next_trap_ec;
  logic [31:0] next_rdata;
  always_comb begin
    next_done = verdict != ccfa_none;
    next_undef = verdict == ccfa_undef;
    next_trap = verdict == ccfa_trap;
    next_trap_el = next_trap ? chk_el : 2'h0;
    next_trap_ec = next_trap ? `CCFA_EC_TRAP : 6'h00;
    next_rdata = (verdict == ccfa_ok && !cp_write) ? filter : 32'h0000_0000;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cp_done <= 1'b0;
      cp_undef <= 1'b0;
      cp_trap <= 1'b0;
      cp_trap_el <= 2'h0;
      cp_trap_ec <= 6'h00;
      cp_rdata <= 32'h0000_0000;
    end else begin
      cp_done <= next_done;
      cp_undef <= next_undef;
      cp_trap <= next_trap;
      cp_trap_el <= next_trap_el;
      cp_trap_ec <= next_trap_ec;
      cp_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // cycle counter
  // ----------------------------------------
  logic gate_ok;
  ccfa_count_gate #(
    .HAVE_EL2(HAVE_EL2),
    .HAVE_EL3(HAVE_EL3),
    .HAVE_REALM(HAVE_REALM)
  ) u_gate (
    .filter(filter),
    .cur_el(cur_el),
    .cur_ss(cur_ss),
    .count_ok(gate_ok)
  );
  assign count_active = gate_ok && PRESENT;

  logic [63:0] next_counter;
  always_comb begin
    next_counter = cycle_counter;
    if (count_active) begin
      next_counter = cycle_counter + 64'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cycle_counter <= 64'h0;
    end else begin
      cycle_counter <= next_counter;
    end
  end
endmodule : ccfa_top

// *** rtl/ccfa_consts.svh ***
// constants for the cycle count filter block
`ifndef CCFA_CONSTS_SVH
`define CCFA_CONSTS_SVH
`define CCFA_P_BIT 31
`define CCFA_U_BIT 30
`define CCFA_NS_KERNEL_BIT 29
`define CCFA_NS_USER_BIT 28
`define CCFA_HYP_BIT 27
`define CCFA_REALM_USER_BIT 21
`define CCFA_WIDTH 32
`define CCFA_CNT_WIDTH 64
`define CCFA_COPROC 4'hf
`define CCFA_OPC1 3'h0
`define CCFA_CRN 4'he
`define CCFA_CRM 4'hf
`define CCFA_OPC2 3'h7
`define CCFA_SEL_CYCLE 5'h1f
`define CCFA_EC_TRAP 6'h03
`define CCFA_FILTER_RESET 32'h0000_0000
`endif

// *** rtl/ccfa_pkg.sv ***
// types shared by the cycle count filter block
package ccfa_pkg;
  typedef enum logic [1:0] {
    ccfa_el0 = 2'h0,
    ccfa_el1 = 2'h1,
    ccfa_el2 = 2'h2,
    ccfa_el3 = 2'h3
  } ccfa_el_e;
  typedef enum logic [1:0] {
    ccfa_sec = 2'h0,
    ccfa_ns = 2'h1,
    ccfa_realm = 2'h2,
    ccfa_root = 2'h3
  } ccfa_ss_e;
  typedef enum logic [3:0] {
    ccfa_ok = 4'h1,
    ccfa_undef = 4'h2,
    ccfa_trap = 4'h4,
    ccfa_none = 4'h8
  } ccfa_res_e;
endpackage : ccfa_pkg

// *** rtl/ccfa_count_gate.sv ***
// combinational decision whether the current cycle is counted
`timescale 1ns/100ps
`include "ccfa_consts.svh"
module ccfa_count_gate
  import ccfa_pkg::*;
#(
  parameter bit HAVE_EL2 = 1'b1,
  parameter bit HAVE_EL3 = 1'b1,
  parameter bit HAVE_REALM = 1'b1
) (
  // filter state
  input wire logic [31:0] filter,
  // processor state
  input wire ccfa_el_e cur_el,
  input wire ccfa_ss_e cur_ss,
  // decision
  output logic count_ok
);
  logic p_bit;
  logic u_bit;
  assign p_bit = filter[`CCFA_P_BIT];
  assign u_bit = filter[`CCFA_U_BIT];

  always_comb begin
    count_ok = 1'b0;
    case (cur_el)
      ccfa_el1: begin
        count_ok = !p_bit;
        if (HAVE_EL3 && cur_ss == ccfa_ns) begin
          count_ok = (filter[`CCFA_NS_KERNEL_BIT] == p_bit);
        end
      end
      ccfa_el0: begin
        count_ok = !u_bit;
        if (HAVE_EL3 && cur_ss == ccfa_ns) begin
          count_ok = (filter[`CCFA_NS_USER_BIT] == u_bit);
        end else if (HAVE_REALM && cur_ss == ccfa_realm) begin
          count_ok = (filter[`CCFA_REALM_USER_BIT] == u_bit);
        end
      end
      ccfa_el2: begin
        count_ok = HAVE_EL2 && filter[`CCFA_HYP_BIT];
      end
      ccfa_el3: begin
        count_ok = 1'b0;
      end
      default: begin
        count_ok = 1'b0;
      end
    endcase
  end
endmodule : ccfa_count_gate

// *** rtl/ccfa_access_check.sv ***
// privilege and trap checks for coprocessor access to the filter
`timescale 1ns/100ps
`include "ccfa_consts.svh"
module ccfa_access_check
  import ccfa_pkg::*;
#(
  parameter bit HAVE_EL3 = 1'b1,
  parameter bit EL3_TRAP_PRIO = 1'b1
) (
  // access context
  input wire logic is_write,
  input wire ccfa_el_e cur_el,
  input wire logic el2_enabled,
  input wire logic halted,
  // trap controls
  input wire logic user_access_enable_bit,
  input wire logic trap_general_exceptions_bit,
  input wire logic host_mode_bit,
  input wire logic fine_trap_permit_bit,
  input wire logic fine_read_trap_bit,
  input wire logic fine_write_trap_bit,
  input wire logic hyp_monitor_trap_bit,
  input wire logic level3_monitor_trap_bit,
  input wire logic secure_debug_disabled_bit,
  // verdict
  output ccfa_res_e result,
  output ccfa_el_e target_el
);
  logic fine_hit;
  logic secure_halt;
  assign secure_halt = halted && HAVE_EL3 && secure_debug_disabled_bit;
  assign fine_hit = is_write ? fine_write_trap_bit : fine_read_trap_bit;

  always_comb begin
    result = ccfa_ok;
    target_el = ccfa_el1;
    // priority follows the documented order of checks
    if (cur_el == ccfa_el0 && secure_halt && EL3_TRAP_PRIO && level3_monitor_trap_bit) begin
      result = ccfa_undef;
    end else if (cur_el == ccfa_el0 && !user_access_enable_bit) begin
      result = ccfa_trap;
      target_el = (el2_enabled && trap_general_exceptions_bit) ? ccfa_el2 : ccfa_el1;
    end else if (cur_el != ccfa_el3 && el2_enabled
                 && !(host_mode_bit && trap_general_exceptions_bit)
                 && (!HAVE_EL3 || fine_trap_permit_bit) && fine_hit) begin
      result = ccfa_trap;
      target_el = ccfa_el2;
    end else if (cur_el != ccfa_el3 && cur_el != ccfa_el2
                 && el2_enabled && hyp_monitor_trap_bit) begin
      result = ccfa_trap;
      target_el = ccfa_el2;
    end else if (cur_el != ccfa_el3 && HAVE_EL3 && level3_monitor_trap_bit) begin
      if (secure_halt) begin
        result = ccfa_undef;
      end else begin
        result = ccfa_trap;
        target_el = ccfa_el3;
      end
    end
  end
endmodule : ccfa_access_check

// *** verif/ccfa_properties.sv ***
// port assertions for the cycle count filter top
`timescale 1ns/100ps
module ccfa_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // request
  input wire logic cp_valid,
  input wire logic cp_indirect,
  input wire logic [4:0] counter_select_field,
  // answer and state
  input wire logic cp_done,
  input wire logic cp_undef,
  input wire logic cp_trap,
  input wire logic [5:0] cp_trap_ec,
  input wire logic [31:0] cp_rdata,
  input wire logic [31:0] cycle_count_filter_view,
  input wire logic [63:0] cycle_counter,
  input wire logic count_active
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence ind_hit;
    cp_valid && cp_indirect && counter_select_field == 5'h1f;
  endsequence
  // reset_n in antecedents keeps the release edge out of the window
  sequence counted;
    reset_n && count_active;
  endsequence
  ind_done_a: assert property (ind_hit |=> cp_done)
    else $error("indirect hit not answered");
  ec_code_a: assert property (cp_trap_ec == (cp_trap ? 6'h03 : 6'h00))
    else $error("trap class wrong");
  rsvd_zero_a: assert property (cycle_count_filter_view[26:22] == 5'h00
      && cycle_count_filter_view[20:0] == 21'h0)
    else $error("reserved filter bits set");
  count_step_a: assert property (counted |=>
      cycle_counter == $past(cycle_counter) + 64'h1)
    else $error("counter missed a counted cycle");
  count_hold_a: assert property (reset_n && !count_active |=> $stable(cycle_counter))
    else $error("counter moved while filtered");
  verdict_excl_a: assert property (cp_done |-> !(cp_undef && cp_trap))
    else $error("undef and trap together");
  verdict_done_a: assert property (cp_undef || cp_trap |-> cp_done)
    else $error("verdict without answer");
  done_cause_a: assert property (cp_done |-> $past(cp_valid))
    else $error("answer without request");
  reset_clear_a: assert property ($rose(reset_n) |->
      cycle_count_filter_view == 32'h0 && cycle_counter == 64'h0)
    else $error("state not cleared by reset");
  rdata_quiet_a: assert property (!cp_done || cp_trap || cp_undef |-> cp_rdata == 32'h0)
    else $error("read data leaked");
endmodule : ccfa_properties

// *** verif/tb.sv ***
// self-checking bench for the cycle count filter block
`timescale 1ns/100ps
module tb
  import ccfa_pkg::*;
;
  // ----
  // signals
  // ----
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cp_valid = 1'b0, cp_write = 1'b0, cp_indirect = 1'b0, ext_write = 1'b0;
  logic [3:0] cp_coproc = 4'hf, cp_crn = 4'he, cp_crm = 4'hf;
  logic [2:0] cp_opc1 = 3'h0, cp_opc2 = 3'h7;
  logic [4:0] counter_select_field = 5'h00;
  logic [31:0] cp_wdata = 32'h0, ext_wdata = 32'h0;
  ccfa_el_e cur_el = ccfa_el1;
  ccfa_ss_e cur_ss = ccfa_sec;
  // trap controls, bit 10 down: el2 enable, halted, user enable, trap general, host mode,
  // fine permit, fine read, fine write, hyp monitor, level 3 monitor, secure debug off
  logic [10:0] ctl = 11'h000;
  logic cp_done, cp_undef, cp_trap, count_active;
  logic [1:0] cp_trap_el;
  logic [5:0] cp_trap_ec;
  logic [31:0] cp_rdata, cycle_count_filter_view;
  logic [63:0] cycle_counter;
  int bad_count = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  ccfa_top uut (.clk, .reset_n, .cp_valid, .cp_write, .cp_coproc, .cp_opc1, .cp_crn,
    .cp_crm, .cp_opc2, .cp_indirect, .counter_select_field, .cp_wdata, .ext_write,
    .ext_wdata, .cur_el, .cur_ss, .el2_enabled(ctl[10]), .halted(ctl[9]),
    .user_access_enable_bit(ctl[8]), .trap_general_exceptions_bit(ctl[7]),
    .host_mode_bit(ctl[6]), .fine_trap_permit_bit(ctl[5]), .fine_read_trap_bit(ctl[4]),
    .fine_write_trap_bit(ctl[3]), .hyp_monitor_trap_bit(ctl[2]),
    .level3_monitor_trap_bit(ctl[1]), .secure_debug_disabled_bit(ctl[0]), .cp_done,
    .cp_undef, .cp_trap, .cp_trap_el, .cp_trap_ec, .cp_rdata, .cycle_count_filter_view,
    .cycle_counter, .count_active);
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic ctx(input ccfa_el_e el, input ccfa_ss_e ss, input logic [10:0] c);
    @(posedge clk);
    cur_el <= el;
    cur_ss <= ss;
    ctl <= c;
  endtask : ctx
  // answer is fixed at one cycle, so no polling is needed
  task automatic acc(input logic w, input logic ind, input logic [31:0] d);
    @(posedge clk);
    cp_valid <= 1'b1;
    cp_write <= w;
    cp_indirect <= ind;
    cp_wdata <= d;
    @(posedge clk);
    cp_valid <= 1'b0;
    #1;
  endtask : acc
  task automatic ans(input logic [2:0] e, input logic [1:0] tel);
    chk("answer", {e, tel, e[0] ? 6'h03 : 6'h00},
      {cp_done, cp_undef, cp_trap, cp_trap_el, cp_trap_ec});
  endtask : ans
  task automatic tcase(input logic w, input ccfa_el_e el, input logic [10:0] c,
      input logic [2:0] e, input logic [1:0] tel);
    ctx(el, ccfa_ns, c);
    acc(w, 1'b0, 32'h0);
    ans(e, tel);
  endtask : tcase
  task automatic cnt(input logic [31:0] f, input ccfa_el_e el, input ccfa_ss_e ss,
      input logic exp);
    logic [63:0] c0;
    @(posedge clk);
    ext_write <= 1'b1;
    ext_wdata <= f;
    cur_el <= el;
    cur_ss <= ss;
    @(posedge clk);
    ext_write <= 1'b0;
    #1;
    chk("count active", exp, count_active);
    c0 = cycle_counter;
    @(posedge clk);
    #1;
    chk("counter", c0 + exp, cycle_counter);
  endtask : cnt
  task automatic t_filter;
    ctx(ccfa_el1, ccfa_sec, 11'h000);
    acc(1'b1, 1'b0, 32'hffff_ffff);
    ans(3'b100, 2'h0);
    chk("filter", 32'hf820_0000, cycle_count_filter_view);
    acc(1'b0, 1'b0, 32'h0);
    chk("read", 32'hf820_0000, cp_rdata);
    @(posedge clk);
    cp_crm <= 4'he;
    counter_select_field <= 5'h1e;
    acc(1'b0, 1'b1, 32'h0);
    ans(3'b000, 2'h0);
    @(posedge clk);
    counter_select_field <= 5'h1f;
    acc(1'b0, 1'b1, 32'h0);
    chk("indirect", 32'hf820_0000, cp_rdata);
    acc(1'b1, 1'b0, 32'h0);
    ans(3'b000, 2'h0);
    @(posedge clk);
    cp_crm <= 4'hf;
  endtask : t_filter
  task automatic t_trap;
    tcase(1'b1, ccfa_el0, 11'h000, 3'b101, 2'h1);
    tcase(1'b0, ccfa_el0, 11'h480, 3'b101, 2'h2);
    tcase(1'b0, ccfa_el0, 11'h303, 3'b110, 2'h0);
    tcase(1'b0, ccfa_el1, 11'h430, 3'b101, 2'h2);
    tcase(1'b1, ccfa_el1, 11'h428, 3'b101, 2'h2);
    tcase(1'b0, ccfa_el1, 11'h428, 3'b100, 2'h0);
    tcase(1'b0, ccfa_el1, 11'h4f0, 3'b100, 2'h0);
    tcase(1'b0, ccfa_el1, 11'h410, 3'b100, 2'h0);
    tcase(1'b1, ccfa_el1, 11'h404, 3'b101, 2'h2);
    tcase(1'b0, ccfa_el1, 11'h002, 3'b101, 2'h3);
    tcase(1'b1, ccfa_el1, 11'h203, 3'b110, 2'h0);
    chk("refused writes", 32'hf820_0000, cycle_count_filter_view);
  endtask : t_trap
  task automatic t_count;
    cnt(32'h0000_0000, ccfa_el1, ccfa_sec, 1'b1);
    cnt(32'h8000_0000, ccfa_el1, ccfa_sec, 1'b0);
    cnt(32'h4000_0000, ccfa_el0, ccfa_sec, 1'b0);
    cnt(32'h0000_0000, ccfa_el0, ccfa_sec, 1'b1);
    cnt(32'h2000_0000, ccfa_el1, ccfa_ns, 1'b0);
    cnt(32'ha000_0000, ccfa_el1, ccfa_ns, 1'b1);
    cnt(32'h1000_0000, ccfa_el0, ccfa_ns, 1'b0);
    cnt(32'h5000_0000, ccfa_el0, ccfa_ns, 1'b1);
    cnt(32'h0800_0000, ccfa_el2, ccfa_ns, 1'b1);
    cnt(32'h0000_0000, ccfa_el2, ccfa_ns, 1'b0);
    cnt(32'h0000_0000, ccfa_el3, ccfa_root, 1'b0);
    cnt(32'h0020_0000, ccfa_el0, ccfa_realm, 1'b0);
    cnt(32'h4020_0000, ccfa_el0, ccfa_realm, 1'b1);
    chk("ext view", 32'h4020_0000, cycle_count_filter_view);
  endtask : t_count
  task automatic t_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk("reset filter", 32'h0, cycle_count_filter_view);
    chk("reset counter", 64'h0, cycle_counter);
  endtask : t_reset
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_filter();
    t_trap();
    t_count();
    t_reset();
    wrap_up();
  end
endmodule : tb
bind ccfa_top ccfa_properties chk_i (.clk, .reset_n, .cp_valid, .cp_indirect,
  .counter_select_field, .cp_done, .cp_undef, .cp_trap, .cp_trap_ec, .cp_rdata,
  .cycle_count_filter_view, .cycle_counter, .count_active);
